/* File: clock_gear_pkg.sv */
// package for the clock gear and prescaler control block
// assumes a 32-bit word register port reached by byte offset
package clock_gear_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_SYS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_OSC_CTRL  = 8'h04;
    // system control field positions
    localparam int GEAR_LSB      = 0;
    localparam int PRESC_LSB     = 8;
    localparam int SRC0_BIT      = 12;
    localparam int SRC1_BIT      = 13;
    localparam int CKOUT_LSB     = 16;
    localparam int ADCSTOP_BIT   = 20;
    // oscillation control field positions
    localparam int WSTART_BIT    = 0;
    localparam int WFLAG_BIT     = 1;
    localparam int OSCSEL_BIT    = 17;
    localparam int EXTUSE_BIT    = 18;
    localparam int WSRC_BIT      = 19;
    localparam int WCNT_LSB      = 20;
    // reset values
    localparam logic [2:0]  GEAR_RST   = 3'h0;
    localparam logic [2:0]  PRESC_RST  = 3'h0;
    localparam logic [1:0]  CKOUT_RST  = 2'h1;
    localparam logic [11:0] WCNT_RST   = 12'h800;
    // divider width: longest ratio is 32
    localparam int DIV_W = 5;
    // bus request carrier
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;
    // warm-up state
    typedef enum logic [0:0] {W_IDLE, W_RUN} warm_state_t;
endpackage

/* File: clock_div_en.sv */
// enable-pulse divider: pulse once every 2**shift cycles of an enable
// assumes one system clock; shift 0 passes the input enable through
module clock_div_en #(
    parameter int W = clock_gear_pkg::DIV_W
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         rstn_i,
    // control
    input  wire logic         en_i,
    input  wire logic [2:0]   shift_i,
    // output
    output logic              en_o
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] mask;

    // mask of counter bits that must all be set
    assign mask = W'((1 << shift_i) - 1);
    assign en_o = en_i && ((cnt_r & mask) == mask);

    // free counter stepped by the input enable
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            cnt_r <= '0;
        end else if (en_i) begin
            cnt_r <= cnt_r + W'(1);
        end
    end
endmodule

/* File: clock_gear_prescaler_control.sv */
// clock gear, peripheral source, prescaler, clock out and warm-up control
// assumes a word register port on the system clock; all clocks are enables
// Functional notes
// [RULE1] adc clock stop bit 20: 0 runs, 1 gates both converter clocks; runs at reset; the block has one adc clock output, which it gates
// [RULE2] software confirms conversions ended before stopping the converter clock
// [RULE3] clock out select bits 17-16: low-speed, half system, system, prescaler base
// [RULE4] source0 bit 12 geared or ungeared clock; source1 bit 13 prescaler or system
// [RULE5] prescaler bits 10-8 divide base by 1 to 32; codes 110 and 111 reserved
// [RULE6] gear bits 2-0: 000 undivided, 100..111 divide by 2..16; 001..011 reserved
// [RULE7] software avoids gear divide-by-16 while the tick timer runs
// [RULE8] warm-up count bits 31-20 are the upper twelve bits of a 16-bit timer
// [RULE9] warm-up source bit 19 picks internal or external high-speed oscillator
// [RULE10] software matches warm-up source to oscillator select before low power
// [RULE11] software sets external oscillator use bit 18 before using crystal pins
// [RULE12] oscillator select bit 17 switches high-speed source internal or external
// [RULE13] warm-up start bit 0 starts timer, reads 0; bit 1 reads 1 while running
// [RULE14] reserved bits read zero; reserved gear or prescaler codes keep old value
module clock_gear_prescaler_control #(
    parameter int WARM_W = 16
) (
    // clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     rstn_i,
    // register port
    input  wire clock_gear_pkg::reg_req_t req_i,
    output logic [31:0]                   rdata_o,
    // clock sources as enables
    input  wire logic                     int_hs_osc_en_i,
    input  wire logic                     ext_hs_osc_en_i,
    input  wire logic                     low_speed_clock_en_i,
    // clock enables out
    output logic                          high_speed_clock_en_o,
    output logic                          sys_clock_en_o,
    output logic                          periph_base_en_o,
    output logic                          prescaler_en_o,
    output logic                          adc_clock_en_o,
    output logic                          clock_out_pin_o,
    // oscillator status
    output logic                          ext_hs_osc_use_o,
    output logic                          warmup_active_flag_o
);
    // control register fields
    logic [2:0]  gear_r;
    logic [2:0]  presc_r;
    logic        src0_r;
    logic        src1_r;
    logic [1:0]  ckout_r;
    logic        adc_stop_r;
    logic [11:0] wcnt_r;
    logic        wsrc_r;
    logic        ext_use_r;
    logic        oscsel_r;
    // warm-up counter and state
    logic [WARM_W-1:0] wtimer_r;
    clock_gear_pkg::warm_state_t wstate_r;

    // decoded strobes and internal enables
    logic        wr_sys;
    logic        wr_osc;
    logic [2:0]  gear_shift;
    logic        hs_en;
    logic        gear_en;
    logic        base_src0;
    logic        presc_en;
    logic        half_sys_en;
    logic        warm_tick;
    logic        clk_out_nxt;

    // write strobes; unmapped offsets are ignored
    assign wr_sys = req_i.wr && (req_i.addr == clock_gear_pkg::OFS_SYS_CTRL);
    assign wr_osc = req_i.wr && (req_i.addr == clock_gear_pkg::OFS_OSC_CTRL);

    // system control fields; reserved codes are dropped
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            gear_r     <= clock_gear_pkg::GEAR_RST;
            presc_r    <= clock_gear_pkg::PRESC_RST;
            src0_r     <= 1'b0;
            src1_r     <= 1'b0;
            ckout_r    <= clock_gear_pkg::CKOUT_RST;
            adc_stop_r <= 1'b0;
        end else if (wr_sys) begin
            // a reserved code would decode as undivided (shift 0), so it is dropped
            if (req_i.wdata[2:0] == 3'h0 || req_i.wdata[2]) begin
                gear_r <= req_i.wdata[2:0]; // RULE14
            end
            if (req_i.wdata[10:9] != 2'h3) begin
                presc_r <= req_i.wdata[10:8]; // RULE14
            end
            src0_r     <= req_i.wdata[clock_gear_pkg::SRC0_BIT];
            src1_r     <= req_i.wdata[clock_gear_pkg::SRC1_BIT];
            ckout_r    <= req_i.wdata[17:16];
            adc_stop_r <= req_i.wdata[clock_gear_pkg::ADCSTOP_BIT];
        end
    end

    // oscillation control fields
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            wcnt_r    <= clock_gear_pkg::WCNT_RST; // RULE8
            wsrc_r    <= 1'b0;
            ext_use_r <= 1'b0;
            oscsel_r  <= 1'b0;
        end else if (wr_osc) begin
            wcnt_r    <= req_i.wdata[31:20];
            wsrc_r    <= req_i.wdata[clock_gear_pkg::WSRC_BIT];
            ext_use_r <= req_i.wdata[clock_gear_pkg::EXTUSE_BIT];
            oscsel_r  <= req_i.wdata[clock_gear_pkg::OSCSEL_BIT];
        end
    end

    // high-speed source and gear
    assign hs_en = oscsel_r ? ext_hs_osc_en_i : int_hs_osc_en_i; // RULE12
    // gear codes 100..111 become shifts 1..4, code 000 shift 0
    assign gear_shift = gear_r[2] ? {1'b0, gear_r[1:0]} + 3'h1 : 3'h0; // RULE6

    // geared system enable
    clock_div_en u_gear (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .en_i    (hs_en),
        .shift_i (gear_shift),
        .en_o    (gear_en)
    );

    // peripheral base clock selection
    assign base_src0 = src0_r ? hs_en : gear_en; // RULE4

    // prescaler divides the source-0 base; reserved ratios never reach it
    clock_div_en u_presc (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .en_i    (base_src0),
        .shift_i (presc_r),
        .en_o    (presc_en)
    ); // RULE5

    // half-rate system enable for the clock out pin
    clock_div_en u_half (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .en_i    (gear_en),
        .shift_i (3'h1),
        .en_o    (half_sys_en)
    );

    // enables handed to the rest of the device
    assign high_speed_clock_en_o = hs_en;
    assign sys_clock_en_o        = gear_en;
    assign prescaler_en_o        = presc_en;
    assign periph_base_en_o      = src1_r ? gear_en : base_src0; // RULE4
    assign adc_clock_en_o        = gear_en && !adc_stop_r; // RULE1

    // clock out pin toggles on the selected enable
    always_comb begin
        case (ckout_r)
            2'h0:    clk_out_nxt = low_speed_clock_en_i; // RULE3
            2'h1:    clk_out_nxt = half_sys_en;
            2'h2:    clk_out_nxt = gear_en;
            2'h3:    clk_out_nxt = base_src0;
            default: clk_out_nxt = 1'b0;
        endcase
    end

    // registered pin: toggling once per enable keeps a clean duty cycle
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            clock_out_pin_o <= 1'b0;
        end else if (clk_out_nxt) begin
            clock_out_pin_o <= !clock_out_pin_o;
        end
    end

    // warm-up timer counts the chosen oscillator up to the programmed value
    assign warm_tick = wsrc_r ? ext_hs_osc_en_i : int_hs_osc_en_i; // RULE9

    // a start while running is ignored; only idle accepts a new start
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            wstate_r <= clock_gear_pkg::W_IDLE;
            wtimer_r <= '0;
        end else begin
            case (wstate_r)
                clock_gear_pkg::W_IDLE: begin
                    if (wr_osc && req_i.wdata[clock_gear_pkg::WSTART_BIT]) begin
                        wstate_r <= clock_gear_pkg::W_RUN; // RULE13
                        wtimer_r <= '0;
                    end
                end
                clock_gear_pkg::W_RUN: begin
                    // stop once the upper timer bits reach the programmed count
                    if (warm_tick) begin
                        if (wtimer_r[WARM_W-1 -: 12] >= wcnt_r) begin // RULE8
                            wstate_r <= clock_gear_pkg::W_IDLE;
                        end else begin
                            wtimer_r <= wtimer_r + WARM_W'(1);
                        end
                    end
                end
                default: wstate_r <= clock_gear_pkg::W_IDLE;
            endcase
        end
    end

    // status outputs straight from flip-flops
    assign warmup_active_flag_o = (wstate_r == clock_gear_pkg::W_RUN);
    assign ext_hs_osc_use_o     = ext_use_r;

    // read data is registered and shows one cycle after the read strobe
    // read data, reserved bits and start bit read zero
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            rdata_o <= 32'h0;
        end else if (req_i.rd) begin
            case (req_i.addr)
                clock_gear_pkg::OFS_SYS_CTRL: rdata_o <= {11'h0, adc_stop_r, 2'h0, ckout_r,
                    2'h0, src1_r, src0_r, 1'b0, presc_r, 5'h0, gear_r}; // RULE14
                clock_gear_pkg::OFS_OSC_CTRL: rdata_o <= {wcnt_r, wsrc_r, ext_use_r,
                    oscsel_r, 15'h0, warmup_active_flag_o, 1'b0}; // RULE13
                default: rdata_o <= 32'h0;
            endcase
        end
    end
endmodule

/* File: clock_gear_sva.sv */
// assertions on the clock gear control ports
// bound to the top module; sees its ports only
module clock_gear_sva (
    // clock and reset
    input wire logic                     clock_i,
    input wire logic                     rstn_i,
    // register port
    input wire clock_gear_pkg::reg_req_t req_i,
    input wire logic [31:0]              rdata_o,
    // clock enables and status
    input wire logic                     int_hs_osc_en_i,
    input wire logic                     ext_hs_osc_en_i,
    input wire logic                     high_speed_clock_en_o,
    input wire logic                     sys_clock_en_o,
    input wire logic                     periph_base_en_o,
    input wire logic                     adc_clock_en_o,
    input wire logic                     ext_hs_osc_use_o,
    input wire logic                     warmup_active_flag_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // decoded requests
    wire logic ws = req_i.wr && req_i.addr == 8'h00;
    wire logic wo = req_i.wr && req_i.addr == 8'h04;
    wire logic rs = req_i.rd && req_i.addr == 8'h00;
    wire logic ru = req_i.rd && req_i.addr != 8'h00 && req_i.addr != 8'h04;
    logic       sel_r;
    logic       stop_r;
    logic       src0_r;
    logic       src1_r;
    logic [2:0] gear_r;
    // shadow copies of the control fields; reserved gear codes are skipped
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            {sel_r, stop_r, src0_r, src1_r, gear_r} <= 7'h00;
        end else if (ws) begin
            stop_r <= req_i.wdata[20];
            src0_r <= req_i.wdata[12];
            src1_r <= req_i.wdata[13];
            if (req_i.wdata[2] || req_i.wdata[1:0] == 2'h0) gear_r <= req_i.wdata[2:0];
        end else if (wo) begin
            sel_r <= req_i.wdata[17];
        end
    end
    // warm-up start request while idle
    sequence start_s;
        wo && req_i.wdata[0] && !warmup_active_flag_o;
    endsequence
    AST_ADC_STOP: assert property (stop_r |-> !adc_clock_en_o)
        else $error("adc clock not gated");
    AST_HS_SRC: assert property (high_speed_clock_en_o ==
        (sel_r ? ext_hs_osc_en_i : int_hs_osc_en_i)) else $error("wrong hs source");
    AST_UNGEARED: assert property (gear_r == 3'h0 |->
        sys_clock_en_o == high_speed_clock_en_o) else $error("gear 000 divides");
    AST_SRC0: assert property ((src0_r && !src1_r) |->
        periph_base_en_o == high_speed_clock_en_o) else $error("source 0 not ungeared");
    AST_SRC1: assert property (src1_r |->
        periph_base_en_o == sys_clock_en_o) else $error("source 1 not system clock");
    AST_RSV_SYS: assert property (rs |=> (rdata_o & 32'hFFEC_C8F8) == 32'h0)
        else $error("reserved bits set");
    AST_UNMAPPED: assert property (ru |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    AST_START: assert property (start_s |=> warmup_active_flag_o)
        else $error("warm-up did not start");
    AST_EXTUSE: assert property (wo |=> ext_hs_osc_use_o == $past(req_i.wdata[18]))
        else $error("ext use bit wrong");
endmodule

bind clock_gear_prescaler_control clock_gear_sva sva_i (
    .clock_i, .rstn_i, .req_i, .rdata_o, .int_hs_osc_en_i, .ext_hs_osc_en_i,
    .high_speed_clock_en_o, .sys_clock_en_o, .periph_base_en_o, .adc_clock_en_o,
    .ext_hs_osc_use_o, .warmup_active_flag_o
);

/* File: tb.sv */
// testbench for the clock gear control block
// drives register port and clock enables at the falling edge
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                     clk = 1'b0;
    logic                     rstn = 1'b0;
    logic                     ie = 1'b0;
    logic                     ee = 1'b0;
    logic                     le = 1'b0;
    clock_gear_pkg::reg_req_t req = '0;
    logic [31:0]              rdata, v, w, ex;
    logic                     hs, sc, pb, pe, ae, pin, eu, wf;
    int                       n_fail = 0, checks_done = 0, k, cnt[6];
    // device under test
    clock_gear_prescaler_control uut (
        .clock_i(clk), .rstn_i(rstn), .req_i(req), .rdata_o(rdata),
        .int_hs_osc_en_i(ie), .ext_hs_osc_en_i(ee), .low_speed_clock_en_i(le),
        .high_speed_clock_en_o(hs), .sys_clock_en_o(sc), .periph_base_en_o(pb),
        .prescaler_en_o(pe), .adc_clock_en_o(ae), .clock_out_pin_o(pin),
        .ext_hs_osc_use_o(eu), .warmup_active_flag_o(wf)
    );
    // clock, 10 ns period
    initial begin
        forever #5 clk = ~clk;
    end
    // watchdog against a hang
    initial begin
        #100000;
        n_fail++;
        give_verdict();
    end
    task automatic give_verdict();
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one access; read data kept in v
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        req = '{wr, !wr, a, d};
        @(negedge clk);
        req = '0;
        @(negedge clk);
        v = rdata;
    endtask
    // count enables, pin toggles and adc enables over 64 cycles
    task automatic meas();
        logic p;
        cnt = '{default: 0};
        @(negedge clk);
        p = pin;
        repeat (64) begin
            @(negedge clk);
            cnt[0] += sc;
            cnt[1] += pe;
            cnt[2] += (pin != p);
            cnt[3] += ae;
            cnt[4] += pb;
            cnt[5] += hs;
            p = pin;
        end
    endtask
    // system control after a write; reserved codes keep the old field
    function automatic logic [31:0] f_sys(input logic [31:0] o, input logic [31:0] d);
        f_sys = d & 32'h0013_3000;
        f_sys[10:8] = (d[10:9] == 2'h3) ? o[10:8] : d[10:8];
        f_sys[2:0] = (d[2] || d[1:0] == 2'h0) ? d[2:0] : o[2:0];
    endfunction
    // main sequence
    initial begin
        void'($urandom(35));
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        acc(1'b0, 8'h00, 32'h0);
        chk("sys reset", v, 32'h0001_0000);
        acc(1'b0, 8'h04, 32'h0);
        chk("osc reset", v, 32'h8000_0000);
        acc(1'b1, 8'h08, 32'hFFFF_FFFF);
        acc(1'b0, 8'h08, 32'h0);
        chk("unmapped", v, 32'h0);
        ex = 32'h0001_0000;
        for (k = 0; k < 8; k++) begin
            w = $urandom();
            acc(1'b1, 8'h00, w);
            ex = f_sys(ex, w);
            acc(1'b0, 8'h00, 32'h0);
            chk("sys", v, ex);
            w = $urandom() & 32'hFFFF_FFFE;
            acc(1'b1, 8'h04, w);
            acc(1'b0, 8'h04, 32'h0);
            chk("osc", v, w & 32'hFFFE_0000);
            chk("ext use", eu, w[18]);
        end
        // random oscillator settings are cleared so the internal source drives
        acc(1'b1, 8'h04, 32'h0);
        ie = 1'b1;
        for (k = 0; k < 5; k++) begin
            acc(1'b1, 8'h00, 32'h0002_0000 | ((k == 0) ? 32'h0 : 32'(k + 3)));
            meas();
            chk("gear", cnt[0], 64 >> k);
            chk("sys pin", cnt[2], 64 >> k);
            chk("geared base", cnt[1], 64 >> k);
            chk("periph base", cnt[4], 64 >> k);
        end
        acc(1'b1, 8'h00, 32'h1);
        meas();
        chk("gear kept", cnt[0], 4);
        for (k = 0; k < 7; k++) begin
            acc(1'b1, 8'h00, 32'h0001_1000 | (32'(k) << 8));
            meas();
            chk("presc", cnt[1], 64 >> ((k == 6) ? 5 : k));
            chk("half pin", cnt[2], 32);
            chk("adc run", cnt[3], 64);
            chk("ungeared base", cnt[4], 64);
        end
        acc(1'b1, 8'h00, 32'h0000_3006);
        meas();
        chk("src1 system", cnt[4], 8);
        chk("src1 gear", cnt[0], 8);
        chk("hs enable", cnt[5], 64);
        le = 1'b1;
        acc(1'b1, 8'h00, 32'h0010_0007);
        meas();
        chk("low pin", cnt[2], 64);
        chk("adc stop", cnt[3], 0);
        le = 1'b0;
        acc(1'b1, 8'h00, 32'h0003_0000);
        meas();
        chk("base pin", cnt[2], 64);
        ie = 1'b0;
        ee = 1'b1;
        acc(1'b1, 8'h04, 32'h0002_0000);
        meas();
        chk("ext source", cnt[0], 64);
        acc(1'b1, 8'h04, 32'h0);
        meas();
        chk("int source", cnt[0], 0);
        ie = 1'b1;
        ee = 1'b0;
        acc(1'b1, 8'h04, 32'h001A_0001);
        repeat (40) @(negedge clk);
        acc(1'b0, 8'h04, 32'h0);
        chk("warm run", v, 32'h001A_0002);
        ee = 1'b1;
        k = 0;
        while (wf === 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        chk("warm len", k >= 15 && k <= 18, 1);
        acc(1'b0, 8'h04, 32'h0);
        chk("warm done", v, 32'h001A_0000);
        give_verdict();
    end
endmodule
